/* hw/sram_sync_port.sv */
/*
  Synchronous bus port of a pipelined burst static memory, with the array.
  Assumes inputs synchronous to clock; the pad ring resolves the pins.
*/
`timescale 1ns/1ps

// Summary of operation
// - The third chip select is sampled each edge and joins the other two.
// - Without the third select pin, that select counts as always asserted.
// - Low output enable drives data and parity; high releases them.
// - The first read clock after deselect keeps the outputs undriven.
// - A low burst step during a burst moves to the next location.
// - A low processor strobe captures the address and loads the counter.
// - A low controller strobe captures the address and loads the counter.
// - With both strobes low only the processor strobe is acted on.
// - The processor strobe is ignored while the first select is high.
// - A high sleep request enters a quiet state keeping the contents.
// - Input data and parity are captured on the rising edge.
// - Read data appears one clock after its address is registered.
// - The first chip select is active low and sampled on the edge.
// - The second chip select is active high and sampled on the edge.
// - A low order strap gives linear bursts, high gives interleaved.
module sram_sync_port #(
  parameter int ADDR_W       = sram_port_pkg::ADDR_W,
  parameter int HAS_THIRD_CS = 1
) (
  input  wire logic                           clock,
  input  wire logic                           rst_n,
  input  wire sram_port_pkg::bus_ctl_t        ctl,
  input  wire logic [ADDR_W-1:0]              address,
  input  wire logic                           output_enable_n,
  input  wire logic                           sleep_request,
  input  wire logic                           burst_order,
  input  wire sram_port_pkg::word_t           word_in,
  output sram_port_pkg::word_t                word_out,
  output logic                                word_oe,
  output logic                                sleep_active
);

  // The array is flat, so wide addresses would exhaust simulation memory.
  if (ADDR_W < sram_port_pkg::BURST_W + 1 || ADDR_W > 24)
  begin : g_bad_addr_w
    $error("sram_sync_port: unsupported ADDR_W");
  end

  // ***************************************************************
  // Select and strobe decode
  // ***************************************************************
  logic third_sel;
  logic selected;
  logic proc_take;
  logic ctrl_take;
  logic load;
  logic deselect;
  logic step;

  always_comb
  begin
    third_sel = (HAS_THIRD_CS == 0) ? 1'b1 : !ctl.chip_select_third_low;
    selected  = !ctl.chip_select_first_low && ctl.chip_select_second_high
                && third_sel;
    proc_take = !ctl.proc_addr_strobe_n && !ctl.chip_select_first_low;
    ctrl_take = !ctl.ctrl_addr_strobe_n && ctl.proc_addr_strobe_n;
    load      = (proc_take || ctrl_take) && selected && !sleep_request;
    // A controller strobe with the processor strobe high, or a processor strobe with the first select low, while unselected is a deselect cycle; steps never deselect.
    deselect  = (proc_take || ctrl_take) && !selected;
    step      = !load && !ctl.burst_step_n && !sleep_request;
  end

  // ***************************************************************
  // Address and burst counter
  // ***************************************************************
  localparam int BW = sram_port_pkg::BURST_W;
  logic [ADDR_W-1:0] base_addr;
  logic [ADDR_W-1:0] next_base_addr;
  logic [BW-1:0]     burst_cnt;
  logic [BW-1:0]     next_burst_cnt;
  logic              writing;
  logic              next_writing;
  sram_port_pkg::port_state_t state;
  sram_port_pkg::port_state_t next_state;

  function automatic logic [BW-1:0] burst_index(
    input logic [BW-1:0] start,
    input logic [BW-1:0] count,
    input logic          linear
  );
    burst_index = linear ? BW'(start + count) : (start ^ count);
  endfunction

  logic [BW-1:0] cur_low;

  always_comb
  begin
    next_base_addr = base_addr;
    next_burst_cnt = burst_cnt;
    // A write lasts one data edge, so an idle selected bus never rewrites.
    next_writing   = 1'b0;
    next_state     = state;
    if (load)
    begin
      next_base_addr = address;
      next_burst_cnt = sram_port_pkg::BURST_RESET;
      next_writing   = !ctl.write_n;
    end
    else if (step && state != sram_port_pkg::ST_DESELECTED)
    begin
      next_burst_cnt = BW'(burst_cnt + 1'b1);
      next_writing   = !ctl.write_n;
    end
    unique case (state)
      sram_port_pkg::ST_DESELECTED:
        if (load)
          next_state = sram_port_pkg::ST_FIRST_READ;
      sram_port_pkg::ST_FIRST_READ,
      sram_port_pkg::ST_ACTIVE:
        if (deselect)
          next_state = sram_port_pkg::ST_DESELECTED;
        else
          next_state = sram_port_pkg::ST_ACTIVE;
      default:
        next_state = sram_port_pkg::ST_DESELECTED;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      base_addr <= '0;
      burst_cnt <= sram_port_pkg::BURST_RESET;
      writing   <= 1'b0;
      state     <= sram_port_pkg::ST_DESELECTED;
    end
    else
    begin
      base_addr <= next_base_addr;
      burst_cnt <= next_burst_cnt;
      writing   <= next_writing;
      state     <= next_state;
    end
  end

  // ***************************************************************
  // Array, write capture and pipelined read
  // ***************************************************************
  // Write data is taken one edge after the address, as in late-write parts.
  sram_port_pkg::word_t mem [0:(1<<ADDR_W)-1];
  logic [ADDR_W-1:0]    cur_addr;
  sram_port_pkg::word_t next_word_out;
  logic                 next_word_oe;
  logic                 next_sleep;

  always_comb
  begin
    cur_low  = burst_index(base_addr[BW-1:0], burst_cnt,
                           burst_order == sram_port_pkg::ORDER_LINEAR);
    cur_addr = {base_addr[ADDR_W-1:BW], cur_low};
    next_word_out = (state != sram_port_pkg::ST_DESELECTED && !writing)
                    ? mem[cur_addr] : word_out;
    next_word_oe  = !output_enable_n && !writing && !sleep_request
                    && state == sram_port_pkg::ST_ACTIVE;
    next_sleep    = sleep_request;
  end

  always_ff @(posedge clock)
  begin
    if (state != sram_port_pkg::ST_DESELECTED && writing && !sleep_request)
      mem[cur_addr] <= word_in;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      word_out     <= '0;
      word_oe      <= 1'b0;
      sleep_active <= 1'b0;
    end
    else
    begin
      word_out     <= next_word_out;
      word_oe      <= next_word_oe;
      sleep_active <= next_sleep;
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  sequence seq_load;
    !ctl.proc_addr_strobe_n && !ctl.chip_select_first_low && selected
      && !sleep_request;
  endsequence

  // A read that starts from the deselected state has its first word hidden.
  sequence seq_fresh_read;
    state == sram_port_pkg::ST_DESELECTED && load && ctl.write_n;
  endsequence

  // Late write: the data edge follows the address edge by one clock.
  sequence seq_late_write;
    state != sram_port_pkg::ST_DESELECTED && writing && !sleep_request;
  endsequence

  chk_proc_load_addr: assert property (
    @(posedge clock) disable iff (!rst_n)
    seq_load |=> base_addr == $past(address) && burst_cnt == 2'h0)
    else $error("processor strobe did not load the address");

  chk_ctrl_load_addr: assert property (
    @(posedge clock) disable iff (!rst_n)
    ctl.proc_addr_strobe_n && !ctl.ctrl_addr_strobe_n && selected
      && !sleep_request |=> base_addr == $past(address))
    else $error("controller strobe did not load the address");

  chk_both_strobes_proc: assert property (
    @(posedge clock) disable iff (!rst_n)
    !ctl.proc_addr_strobe_n && !ctl.ctrl_addr_strobe_n
      && ctl.chip_select_first_low |=> base_addr == $past(base_addr))
    else $error("controller strobe acted beside processor strobe");

  chk_proc_ignored_cs: assert property (
    @(posedge clock) disable iff (!rst_n)
    ctl.chip_select_first_low && ctl.ctrl_addr_strobe_n
      |=> base_addr == $past(base_addr))
    else $error("processor strobe taken with first select high");

  chk_burst_step: assert property (
    @(posedge clock) disable iff (!rst_n)
    step && state != sram_port_pkg::ST_DESELECTED
      |=> burst_cnt == 2'($past(burst_cnt) + 2'h1))
    else $error("burst counter did not advance");

  chk_burst_wrap: assert property (
    @(posedge clock) disable iff (!rst_n)
    step && state != sram_port_pkg::ST_DESELECTED && burst_cnt == 2'h3
      |=> burst_cnt == 2'h0)
    else $error("burst counter did not wrap");

  chk_first_read_mask: assert property (
    @(posedge clock) disable iff (!rst_n)
    state == sram_port_pkg::ST_FIRST_READ |=> !word_oe)
    else $error("outputs driven on first read clock");

  chk_fresh_read_mask: assert property (
    @(posedge clock) disable iff (!rst_n)
    seq_fresh_read |=> ##1 !word_oe)
    else $error("first word after deselect was driven");

  chk_oe_high_release: assert property (
    @(posedge clock) disable iff (!rst_n)
    output_enable_n |=> !word_oe)
    else $error("outputs driven with output enable high");

  chk_read_pipe: assert property (
    @(posedge clock) disable iff (!rst_n)
    state != sram_port_pkg::ST_DESELECTED && !writing
      |=> word_out == $past(mem[cur_addr]))
    else $error("read data not one stage behind its address");

  chk_write_capture: assert property (
    @(posedge clock) disable iff (!rst_n)
    seq_late_write |=> mem[$past(cur_addr)] == $past(word_in))
    else $error("write data not captured on the edge");

  chk_third_select: assert property (
    @(posedge clock) disable iff (!rst_n)
    HAS_THIRD_CS != 0 && ctl.chip_select_third_low
      && state == sram_port_pkg::ST_DESELECTED
      |=> state == sram_port_pkg::ST_DESELECTED)
    else $error("selected with third select high");

  chk_select_decode: assert property (
    @(posedge clock) disable iff (!rst_n)
    (ctl.chip_select_first_low || !ctl.chip_select_second_high)
      && ctl.proc_addr_strobe_n && !ctl.ctrl_addr_strobe_n
      |=> state == sram_port_pkg::ST_DESELECTED)
    else $error("strobe while unselected did not deselect");

  chk_sleep_follow: assert property (
    @(posedge clock) disable iff (!rst_n)
    sleep_request [*2] |-> sleep_active && !word_oe)
    else $error("sleep not entered");

  chk_sleep_hold: assert property (
    @(posedge clock) disable iff (!rst_n)
    sleep_request |=> base_addr == $past(base_addr))
    else $error("address loaded during sleep");

endmodule

/* include/sram_port_pkg.sv */
/*
  Constants and carrier types for the pipelined synchronous memory port.
  Assumes a single rising-edge clock and a processor or controller master.
*/
package sram_port_pkg;

  // ***************************************************************
  // Sizes and reset values
  // ***************************************************************
  localparam int          ADDR_W      = 20;
  localparam int          DATA_W      = 16;
  localparam int          PAR_W       = 2;
  localparam int          BURST_W     = 2;
  localparam logic [1:0]  BURST_RESET = 2'h0;
  localparam logic        ORDER_LINEAR = 1'h0;

  // ***************************************************************
  // Carriers
  // ***************************************************************
  typedef struct packed {
    logic chip_select_first_low;
    logic chip_select_second_high;
    logic chip_select_third_low;
    logic proc_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_step_n;
    logic write_n;
  } bus_ctl_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [PAR_W-1:0]  parity;
  } word_t;

  typedef enum logic [1:0] {
    ST_DESELECTED = 2'b00,
    ST_FIRST_READ = 2'b01,
    ST_ACTIVE     = 2'b10
  } port_state_t;

endpackage

/* verif/bus_master_model.sv */
/*
  Processor or controller bus master model for the memory port.
  Assumes the bench owns the clock and calls one task at a time.
*/
`timescale 1ns/1ps
module bus_master_model (
  input  wire logic                        clock,
  output sram_port_pkg::bus_ctl_t          ctl,
  output logic [sram_port_pkg::ADDR_W-1:0] address,
  output sram_port_pkg::word_t             word_in
);
  // ****************************************************
  // Bus cycles
  // ****************************************************
  localparam logic [6:0] IDLE = 7'h2f;

  initial
  begin
    ctl = IDLE;
    address = '0;
    word_in = '0;
  end

  task automatic xfer(input logic [2:0] cs, input logic [1:0] s,
                      input logic wn, input logic [19:0] a,
                      input sram_port_pkg::word_t d);
    @(posedge clock);
    ctl <= {cs, s, 1'b1, wn};
    address <= a;
    @(posedge clock);
    ctl <= {cs, 2'b11, 1'b1, wn};
    word_in <= d;
    @(posedge clock);
    ctl <= IDLE;
    // Released lines flip so stale data never looks valid.
    word_in <= ~d;
  endtask

  task automatic start_read(input logic [1:0] s, input logic [19:0] a);
    @(posedge clock);
    ctl <= {3'b010, s, 1'b1, 1'b1};
    address <= a;
    @(posedge clock);
    ctl <= {3'b010, 2'b11, 1'b0, 1'b1};
  endtask

  task automatic stop();
    @(posedge clock);
    ctl <= IDLE;
  endtask
endmodule

/* verif/pipelined_sync_sram_port_tb_top.sv */
/*
  Self-checking bench for the synchronous memory port.
  Assumes the master model drives the bus and the bench the static pins.
*/
`timescale 1ns/1ps
module pipelined_sync_sram_port_tb_top;
  logic                             clock;
  logic                             rst_n;
  logic                             output_enable_n;
  logic                             sleep_request;
  logic                             burst_order;
  sram_port_pkg::bus_ctl_t          ctl;
  logic [sram_port_pkg::ADDR_W-1:0] address;
  sram_port_pkg::word_t             word_in;
  sram_port_pkg::word_t             word_out;
  logic                             word_oe;
  logic                             sleep_active;
  sram_port_pkg::word_t             m [16];
  int                               n_fail;
  int                               total_checks;

  bus_master_model bus_master_model_i (.clock(clock), .ctl(ctl),
    .address(address), .word_in(word_in));
  sram_sync_port sram_sync_port_i (.clock(clock), .rst_n(rst_n),
    .ctl(ctl), .address(address), .output_enable_n(output_enable_n),
    .sleep_request(sleep_request), .burst_order(burst_order),
    .word_in(word_in), .word_out(word_out), .word_oe(word_oe),
    .sleep_active(sleep_active));

  // ****************************************************
  // Helpers
  // ****************************************************
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input string n, input logic [17:0] e, s);
    total_checks++;
    if (s !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, s);
      n_fail++;
    end
  endtask

  task automatic wr(input logic [2:0] cs, input logic [1:0] s,
                    input logic [3:0] a, input logic hit);
    sram_port_pkg::word_t d;
    d = hit ? 18'h15a30 + 18'(a) * 18'h01111 : ~m[a];
    bus_master_model_i.xfer(cs, s, 1'b0, {16'h0, a}, d);
    if (hit)
      m[a] = d;
  endtask

  task automatic burst(input logic [1:0] s, input logic [3:0] a,
                       input logic il, oe, msk);
    logic [3:0] x;
    bus_master_model_i.start_read(s, {16'h0, a});
    for (int i = 0; i < 5; i++)
    begin
      @(posedge clock);
      #1;
      x = il ? {a[3:2], a[1:0] ^ i[1:0]} : {a[3:2], a[1:0] + i[1:0]};
      check("word_out", m[x], word_out);
      if (i > 0 || msk)
        check("word_oe", 18'(oe && i > 0), 18'(word_oe));
    end
    bus_master_model_i.stop();
  endtask

  // ****************************************************
  // Scenarios
  // ****************************************************
  task automatic t_write();
    logic [1:0] s;
    for (int i = 0; i < 8; i++)
    begin
      // The last write drives both strobes low so the processor one must win.
      s = (i == 7) ? 2'b00 : (i[0] ? 2'b01 : 2'b10);
      wr(3'b010, s, 4'(i), 1'b1);
    end
    $display("t_write done");
  endtask

  task automatic t_linear();
    bus_master_model_i.xfer(3'b110, 2'b10, 1'b1, '0, '0);
    burst(2'b01, 4'h1, 1'b0, 1'b1, 1'b1);
    burst(2'b10, 4'h6, 1'b0, 1'b1, 1'b0);
    $display("t_linear done");
  endtask

  task automatic t_refuse();
    // An ignored processor strobe must not deselect an active port.
    wr(3'b110, 2'b01, 4'h0, 1'b0);
    #1;
    check("word_oe", 18'h1, 18'(word_oe));
    wr(3'b110, 2'b00, 4'h0, 1'b0);
    wr(3'b110, 2'b10, 4'h0, 1'b0);
    wr(3'b000, 2'b10, 4'h0, 1'b0);
    wr(3'b011, 2'b10, 4'h0, 1'b0);
    wr(3'b110, 2'b01, 4'h0, 1'b0);
    burst(2'b10, 4'h0, 1'b0, 1'b1, 1'b0);
    $display("t_refuse done");
  endtask

  task automatic t_sleep();
    @(posedge clock);
    sleep_request <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check("sleep_active", 18'h1, 18'(sleep_active));
    wr(3'b010, 2'b10, 4'h2, 1'b0);
    sleep_request <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check("sleep_active", 18'h0, 18'(sleep_active));
    burst(2'b10, 4'h0, 1'b0, 1'b1, 1'b0);
    $display("t_sleep done");
  endtask

  task automatic t_inter();
    @(posedge clock);
    rst_n <= 1'b0;
    burst_order <= 1'b1;
    output_enable_n <= 1'b1;
    repeat (2) @(posedge clock);
    #1;
    check("word_out", 18'h0, word_out);
    rst_n <= 1'b1;
    burst(2'b01, 4'h5, 1'b1, 1'b0, 1'b1);
    $display("t_inter done");
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    #100000;
    n_fail++;
    end_of_test();
  end

  initial
  begin
    rst_n = 1'b0;
    output_enable_n = 1'b0;
    sleep_request = 1'b0;
    burst_order = 1'b0;
    n_fail = 0;
    total_checks = 0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    t_write();
    t_linear();
    t_refuse();
    t_sleep();
    t_inter();
    end_of_test();
  end
endmodule
